// ==== hw/afr_pkg.sv ====
// package for the abort fault status recorder: register map, layouts,
// event carriers and encodings shared by the recorder and its bench.
// assumes a 32-bit apb register bus and one 20 MHz processor clock.
`default_nettype none

package afr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // bus and register map (byte addresses, one aligned word each)
  localparam int unsigned AFR_ADDR_W = 8;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_INSTR_FAULT_STATUS     = 8'h00;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_DATA_FAULT_STATUS      = 8'h04;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_INSTR_FAULT_ADDRESS    = 8'h08;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_DATA_FAULT_ADDRESS     = 8'h0c;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_AUX_INSTR_FAULT_STATUS = 8'h10;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_AUX_DATA_FAULT_STATUS  = 8'h14;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_CORRECTABLE_FAULT_LOC  = 8'h18;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_ABORT_SAVED_STATUS     = 8'h1c;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_ABORT_LINK_REGISTER    = 8'h20;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_DEBUG_STATUS_CONTROL   = 8'h24;
  localparam logic [AFR_ADDR_W-1:0] AFR_OFS_CONTROL                = 8'h28;

  localparam logic [31:0] AFR_RST_WORD  = 32'h0000_0000;   // reset of every word
  localparam logic [31:0] AFR_LINK_OFS_INSTR = 32'h0000_0004; // pc offset, fetch abort
  localparam logic [31:0] AFR_LINK_OFS_DATA  = 32'h0000_0008; // pc offset, data abort

  ////////////////////////////////////////////////////////////////////////
  // fault status type codes
  localparam logic [3:0] AFR_FS_MPU      = 4'h1;  // protection fault
  localparam logic [3:0] AFR_FS_DEBUG    = 4'h2;  // debug event
  localparam logic [3:0] AFR_FS_EXT      = 4'h8;  // bus error response
  localparam logic [3:0] AFR_FS_PARITY   = 4'h9;  // parity or ecc error
  localparam logic [3:0] AFR_FS_TCM_EXT  = 4'ha;  // tcm signalled error/retry

  ////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [2:0] {
    AFR_CAUSE_MPU, AFR_CAUSE_BUS_ERR, AFR_CAUSE_CACHE_ECC, AFR_CAUSE_TCM_ECC,
    AFR_CAUSE_TCM_EXT_ERR, AFR_CAUSE_TCM_RETRY, AFR_CAUSE_DEBUG
  } afr_cause_e;

  typedef enum logic [1:0] {
    AFR_SRC_CACHE, AFR_SRC_BUS, AFR_SRC_FIRST_TCM, AFR_SRC_SECOND_TCM
  } afr_src_e;

  typedef enum logic [1:0] {
    AFR_KIND_INSTR, AFR_KIND_DATA, AFR_KIND_DMA
  } afr_kind_e;

  ////////////////////////////////////////////////////////////////////////
  // event carriers
  typedef struct packed {
    logic        valid;            // one-cycle fault report from the pipeline
    logic        instr_side;       // 1 fetch, 0 data access
    logic        mpu_fault;        // protection fault on the same access
    afr_cause_e  cause;            // other cause
    afr_src_e    src;              // where the error was seen
    logic        is_write;         // store side of the access
    logic        strongly_ordered; // store target is strongly ordered
    logic        cache_maint;      // error during cache maintenance
    logic        correctable;      // ecc error that can be corrected
    logic [1:0]  way;              // cache way
    logic [7:0]  set;              // cache set
    logic [31:0] addr;             // faulting access address
    logic [31:0] pc;               // address of aborted instruction
    logic [31:0] psr;              // processor state and mode
  } afr_fault_s;

  typedef struct packed {
    logic        valid;  // one-cycle correctable fault on a dma read
    afr_src_e    src;
    logic [1:0]  way;
    logic [7:0]  set;
  } afr_dma_corr_s;

  ////////////////////////////////////////////////////////////////////////
  // register layouts
  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic        wnr;        // access was a write
    logic        imprecise;  // abort was imprecise
    logic [5:0]  rsvd_lo;
    logic [3:0]  code;       // fault type
  } afr_fs_s;

  typedef struct packed {
    logic [7:0]  rsvd3;
    logic [7:0]  set;        // imprecise reports only
    logic [6:0]  rsvd2;
    logic        recov;      // recoverable error
    logic [1:0]  rsvd1;
    afr_src_e    src;
    logic [1:0]  rsvd0;
    logic [1:0]  way;
  } afr_aux_s;

  typedef struct packed {
    logic [7:0]  rsvd3;
    logic [7:0]  set;
    logic [1:0]  rsvd2;
    afr_kind_e   kind;       // fetch, data or dma
    logic [5:0]  rsvd1;
    afr_src_e    src;
    logic [1:0]  rsvd0;
    logic [1:0]  way;
  } afr_cfl_s;

  typedef struct packed {
    logic [30:0] rsvd;
    logic        sticky_precise_abort;
  } afr_dsc_s;

  typedef struct packed {
    logic [30:0] rsvd;
    logic        abort_on_correctable; // 1: correctable errors abort
  } afr_ctl_s;

endpackage

`default_nettype wire

// ==== hw/afr_recorder.sv ====
// abort fault status recorder: classifies abort reports, records fault
// status, address, auxiliary and saved state, logs correctable faults.
// assumes one report per cycle from the pipeline and an apb master.
//
// The APB interface to the registers and the register addresses were decided locally.
`default_nettype none

module afr_recorder
  import afr_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [AFR_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // fault reports
  input  wire afr_fault_s            i_fault,
  input  wire afr_dma_corr_s         i_dma_corr,
  input  wire logic                  i_debug_halt,
  // results towards the pipeline and interrupt controller
  output logic                       o_abort_take,
  output logic                       o_abort_precise,
  output logic                       o_retry_access,
  output logic                       o_corr_event,
  output logic                       o_sticky_precise_abort
);

  ////////////////////////////////////////////////////////////////////////
  // classification helpers

  // precise or imprecise, by side, cause and direction
  // fetch and protection faults stay precise
  function automatic logic is_precise(input afr_fault_s f);
    logic p;
    p = 1'b1;
    if (!f.instr_side && !f.mpu_fault) begin
      unique case (f.cause)
        AFR_CAUSE_BUS_ERR:     p = !f.is_write || f.strongly_ordered;
        AFR_CAUSE_CACHE_ECC:   p = !f.is_write && !f.cache_maint;
        AFR_CAUSE_TCM_EXT_ERR: p = !f.is_write;
        AFR_CAUSE_TCM_RETRY:   p = !f.is_write;
        default:               p = 1'b1;
      endcase
    end
    return p;
  endfunction

  // recoverable only for correctable ecc or a tcm retry request
  // external tcm errors fall to unrecoverable
  function automatic logic is_recoverable(input afr_fault_s f);
    logic r;
    r = 1'b0;
    if (!f.mpu_fault) begin
      unique case (f.cause)
        AFR_CAUSE_CACHE_ECC,
        AFR_CAUSE_TCM_ECC:     r = f.correctable;
        AFR_CAUSE_TCM_RETRY:   r = 1'b1;
        default:               r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // fault type code seen by the handler
  // a protection fault hides any other cause
  function automatic logic [3:0] type_code(input afr_fault_s f);
    logic [3:0] c;
    c = AFR_FS_MPU;
    if (!f.mpu_fault) begin
      unique case (f.cause)
        AFR_CAUSE_BUS_ERR:     c = AFR_FS_EXT;
        AFR_CAUSE_CACHE_ECC,
        AFR_CAUSE_TCM_ECC:     c = AFR_FS_PARITY;
        AFR_CAUSE_TCM_EXT_ERR,
        AFR_CAUSE_TCM_RETRY:   c = AFR_FS_TCM_EXT;
        AFR_CAUSE_DEBUG:       c = AFR_FS_DEBUG;
        default:               c = AFR_FS_MPU;
      endcase
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  // all words reset to zero and are writable, except debug_status_control, which software can only clear
  afr_fs_s     ifs_q, ifs_d;     // instr_fault_status
  afr_fs_s     dfs_q, dfs_d;     // data_fault_status
  logic [31:0] ifa_q, ifa_d;     // instr_fault_address
  logic [31:0] dfa_q, dfa_d;     // data_fault_address
  afr_aux_s    aifs_q, aifs_d;   // aux_instr_fault_status
  afr_aux_s    adfs_q, adfs_d;   // aux_data_fault_status
  afr_cfl_s    cfl_q, cfl_d;     // correctable_fault_location
  logic [31:0] ass_q, ass_d;     // abort_saved_status
  logic [31:0] alr_q, alr_d;     // abort_link_register
  afr_dsc_s    dsc_q, dsc_d;     // debug_status_control
  afr_ctl_s    ctl_q, ctl_d;     // control
  logic [31:0] rdata_q, rdata_d; // read data
  logic        rerr_q, rerr_d;   // unmapped address
  logic        take_q, take_d;   // abort taken pulse
  logic        prec_q, prec_d;   // taken abort was precise
  logic        retry_q, retry_d; // repeat the access pulse
  logic        cev_q, cev_d;     // correctable error event pulse

  ////////////////////////////////////////////////////////////////////////
  // decode of the incoming report
  // halted recoverable errors neither retry nor abort

  logic f_precise;     // report classifies as precise
  logic f_recov;       // report classifies as recoverable
  logic f_corrfix;     // correctable error or retry with no mpu fault
  logic f_auto;        // handled by hardware, no abort
  logic f_abort;       // an abort exception is taken
  logic f_halt_corr;   // correctable error or retry while halted
  logic f_log;         // pipeline correctable fault to log
  afr_aux_s f_aux;     // aux word for this report

  always_comb begin
    f_precise   = is_precise(i_fault);
    f_recov     = is_recoverable(i_fault);
    f_corrfix   = i_fault.valid && !i_fault.mpu_fault && f_recov;
    f_log       = f_corrfix && i_fault.correctable;
    // halted: corrected, not repeated, no abort exception
    f_halt_corr = f_corrfix && i_debug_halt;
    f_auto      = f_corrfix && !ctl_q.abort_on_correctable;
    f_abort     = i_fault.valid && !f_auto && !f_halt_corr;
    // set field only for imprecise reports
    f_aux       = AFR_RST_WORD;
    f_aux.recov = f_recov && !i_fault.mpu_fault;
    f_aux.src   = i_fault.src;
    f_aux.way   = i_fault.way;
    if (!f_precise) begin
      f_aux.set = i_fault.set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  // zero wait: read data stands in the access phase

  logic apb_setup;  // first cycle of a transfer
  logic apb_wr;     // write completing this cycle
  logic hit;        // address decodes

  always_comb begin
    apb_setup = i_psel && !i_penable;
    apb_wr    = i_psel && i_penable && i_pwrite;
    o_pready  = 1'b1;  // never waits
    unique case (i_paddr)
      AFR_OFS_INSTR_FAULT_STATUS, AFR_OFS_DATA_FAULT_STATUS,
      AFR_OFS_INSTR_FAULT_ADDRESS, AFR_OFS_DATA_FAULT_ADDRESS,
      AFR_OFS_AUX_INSTR_FAULT_STATUS, AFR_OFS_AUX_DATA_FAULT_STATUS,
      AFR_OFS_CORRECTABLE_FAULT_LOC, AFR_OFS_ABORT_SAVED_STATUS,
      AFR_OFS_ABORT_LINK_REGISTER, AFR_OFS_DEBUG_STATUS_CONTROL,
      AFR_OFS_CONTROL: hit = 1'b1;
      default:         hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state: software writes first, hardware updates override them
  // control is never touched by hardware

  always_comb begin
    ifs_d  = ifs_q;
    dfs_d  = dfs_q;
    ifa_d  = ifa_q;
    dfa_d  = dfa_q;
    aifs_d = aifs_q;
    adfs_d = adfs_q;
    cfl_d  = cfl_q;
    ass_d  = ass_q;
    alr_d  = alr_q;
    dsc_d  = dsc_q;
    ctl_d  = ctl_q;
    // register writes, taken at the access phase
    if (apb_wr) begin
      unique case (i_paddr)
        AFR_OFS_INSTR_FAULT_STATUS:     ifs_d  = i_pwdata;
        AFR_OFS_DATA_FAULT_STATUS:      dfs_d  = i_pwdata;
        AFR_OFS_INSTR_FAULT_ADDRESS:    ifa_d  = i_pwdata;
        AFR_OFS_DATA_FAULT_ADDRESS:     dfa_d  = i_pwdata;
        AFR_OFS_AUX_INSTR_FAULT_STATUS: aifs_d = i_pwdata;
        AFR_OFS_AUX_DATA_FAULT_STATUS:  adfs_d = i_pwdata;
        AFR_OFS_CORRECTABLE_FAULT_LOC:  cfl_d  = i_pwdata;
        AFR_OFS_ABORT_SAVED_STATUS:     ass_d  = i_pwdata;
        AFR_OFS_ABORT_LINK_REGISTER:    alr_d  = i_pwdata;
        AFR_OFS_DEBUG_STATUS_CONTROL: begin
          // write one to clear the sticky flag
          // a set in the same cycle still wins below
          if (i_pwdata[0]) begin
            dsc_d.sticky_precise_abort = 1'b0;
          end
        end
        AFR_OFS_CONTROL:                ctl_d.abort_on_correctable = i_pwdata[0];
        default:                        ctl_d = ctl_q;
      endcase
    end
    // abort exception: saved state and link on every abort
    // link offset differs for fetch and data aborts
    if (f_abort) begin
      ass_d = i_fault.psr;
      alr_d = i_fault.pc + (i_fault.instr_side ? AFR_LINK_OFS_INSTR
                                               : AFR_LINK_OFS_DATA);
      if (i_fault.instr_side) begin
        // fetch aborts are always precise
        ifs_d           = AFR_RST_WORD;
        ifs_d.code      = type_code(i_fault);
        ifs_d.wnr       = 1'b0;
        ifs_d.imprecise = 1'b0;
        ifa_d           = i_fault.addr;
        aifs_d          = f_aux;
      end else if (f_precise) begin
        dfs_d           = AFR_RST_WORD;
        dfs_d.code      = type_code(i_fault);
        dfs_d.wnr       = i_fault.is_write;
        dfs_d.imprecise = 1'b0;
        dfa_d           = i_fault.addr;
        adfs_d          = f_aux;
      end else begin
        // imprecise: status and aux only, the address stays
        dfs_d           = AFR_RST_WORD;
        dfs_d.code      = type_code(i_fault);
        dfs_d.wnr       = i_fault.is_write;
        dfs_d.imprecise = 1'b1;
        adfs_d          = f_aux;
      end
    end
    // correctable fault location, newest always wins
    // dma reads are corrected inline, only logged
    if (i_dma_corr.valid) begin
      cfl_d      = AFR_RST_WORD;
      cfl_d.kind = AFR_KIND_DMA;
      cfl_d.src  = i_dma_corr.src;
      cfl_d.way  = i_dma_corr.way;
      cfl_d.set  = i_dma_corr.set;
    end
    if (f_log) begin
      // a pipeline fault is treated as newer than a dma one
      cfl_d      = AFR_RST_WORD;
      cfl_d.kind = i_fault.instr_side ? AFR_KIND_INSTR : AFR_KIND_DATA;
      cfl_d.src  = i_fault.src;
      cfl_d.way  = i_fault.way;
      cfl_d.set  = i_fault.set;
    end
    // sticky flag: the set wins over a clear in the same cycle
    if (f_halt_corr) begin
      dsc_d.sticky_precise_abort = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state of bus answer and result pulses
  // answer registers hold until the next setup

  always_comb begin
    rdata_d = rdata_q;
    rerr_d  = rerr_q;
    // read data captured in the setup cycle, shown in the access phase
    if (apb_setup) begin
      rerr_d = !hit;
      unique case (i_paddr)
        AFR_OFS_INSTR_FAULT_STATUS:     rdata_d = ifs_q;
        AFR_OFS_DATA_FAULT_STATUS:      rdata_d = dfs_q;
        AFR_OFS_INSTR_FAULT_ADDRESS:    rdata_d = ifa_q;
        AFR_OFS_DATA_FAULT_ADDRESS:     rdata_d = dfa_q;
        AFR_OFS_AUX_INSTR_FAULT_STATUS: rdata_d = aifs_q;
        AFR_OFS_AUX_DATA_FAULT_STATUS:  rdata_d = adfs_q;
        AFR_OFS_CORRECTABLE_FAULT_LOC:  rdata_d = cfl_q;
        AFR_OFS_ABORT_SAVED_STATUS:     rdata_d = ass_q;
        AFR_OFS_ABORT_LINK_REGISTER:    rdata_d = alr_q;
        AFR_OFS_DEBUG_STATUS_CONTROL:   rdata_d = dsc_q;
        AFR_OFS_CONTROL:                rdata_d = ctl_q;
        default:                        rdata_d = AFR_RST_WORD;
      endcase
    end
    // pulses follow their report by one cycle
    take_d  = f_abort;
    prec_d  = f_abort && (i_fault.instr_side || f_precise);
    // hardware repeats the access after correction unless halted or abort_on_correctable is set
    retry_d = f_auto && !i_debug_halt;
    cev_d   = f_log || i_dma_corr.valid;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers: hold between qualifying events
  // synchronous reset clears every word

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ifs_q   <= AFR_RST_WORD;
      dfs_q   <= AFR_RST_WORD;
      ifa_q   <= AFR_RST_WORD;
      dfa_q   <= AFR_RST_WORD;
      aifs_q  <= AFR_RST_WORD;
      adfs_q  <= AFR_RST_WORD;
      cfl_q   <= AFR_RST_WORD;
      ass_q   <= AFR_RST_WORD;
      alr_q   <= AFR_RST_WORD;
      dsc_q   <= AFR_RST_WORD;
      ctl_q   <= AFR_RST_WORD;
      rdata_q <= AFR_RST_WORD;
      rerr_q  <= 1'b0;
      take_q  <= 1'b0;
      prec_q  <= 1'b0;
      retry_q <= 1'b0;
      cev_q   <= 1'b0;
    end else begin
      ifs_q   <= ifs_d;
      dfs_q   <= dfs_d;
      ifa_q   <= ifa_d;
      dfa_q   <= dfa_d;
      aifs_q  <= aifs_d;
      adfs_q  <= adfs_d;
      cfl_q   <= cfl_d;
      ass_q   <= ass_d;
      alr_q   <= alr_d;
      dsc_q   <= dsc_d;
      ctl_q   <= ctl_d;
      rdata_q <= rdata_d;
      rerr_q  <= rerr_d;
      take_q  <= take_d;
      prec_q  <= prec_d;
      retry_q <= retry_d;
      cev_q   <= cev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    o_prdata               = rdata_q;
    // slave error shows only in the access phase
    o_pslverr              = rerr_q && i_psel && i_penable;
    o_abort_take           = take_q;
    o_abort_precise        = prec_q;
    o_retry_access         = retry_q;
    o_corr_event           = cev_q;
    o_sticky_precise_abort = dsc_q.sticky_precise_abort;
  end

endmodule

`default_nettype wire

// ==== tb/afr_recorder_properties.sv ====
// checker for the abort fault status recorder ports
// assumes it is bound to afr_recorder and sees only its ports
`default_nettype none
module afr_recorder_properties
  import afr_pkg::*;
(
  input wire logic          i_clock,
  input wire logic          i_rstn,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic [7:0]    i_paddr,
  input wire afr_fault_s    i_fault,
  input wire afr_dma_corr_s i_dma_corr,
  input wire logic          i_debug_halt,
  input wire logic          o_pslverr,
  input wire logic          o_abort_take,
  input wire logic          o_abort_precise,
  input wire logic          o_retry_access,
  input wire logic          o_corr_event,
  input wire logic          o_sticky_precise_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // report without protection fault, data side, correctable, halted recoverable
  wire logic v = i_fault.valid && !i_fault.mpu_fault;
  wire logic dv = v && !i_fault.instr_side;
  wire logic rec = v && i_fault.correctable &&
    (i_fault.cause inside {AFR_CAUSE_CACHE_ECC, AFR_CAUSE_TCM_ECC, AFR_CAUSE_TCM_RETRY});
  wire logic cev = rec || i_dma_corr.valid;
  wire logic hrec = i_debug_halt && (rec || (v && i_fault.cause == AFR_CAUSE_TCM_RETRY));
  ////////////////////////////////////////////////////////////////////////
  AST_MPU_FIRST: assert property (i_fault.valid && i_fault.mpu_fault
    |=> o_abort_take && o_abort_precise) else $error("protection fault not precise");
  AST_FETCH_PRECISE: assert property (v && i_fault.instr_side &&
    i_fault.cause == AFR_CAUSE_BUS_ERR |=> o_abort_take && o_abort_precise)
    else $error("fetch abort not precise");
  AST_LOAD_PRECISE: assert property (dv && i_fault.cause == AFR_CAUSE_BUS_ERR &&
    !i_fault.is_write |=> o_abort_take && o_abort_precise) else $error("load not precise");
  AST_STORE_IMPRECISE: assert property (dv && i_fault.cause == AFR_CAUSE_BUS_ERR &&
    i_fault.is_write && !i_fault.strongly_ordered |=> o_abort_take && !o_abort_precise)
    else $error("store abort not imprecise");
  AST_CACHE_IMPRECISE: assert property (dv && i_fault.cause == AFR_CAUSE_CACHE_ECC &&
    !i_fault.correctable && (i_fault.is_write || i_fault.cache_maint)
    |=> o_abort_take && !o_abort_precise) else $error("cache store abort not imprecise");
  AST_HALT_NO_RETRY: assert property (hrec
    |=> !o_abort_take && !o_retry_access && o_sticky_precise_abort)
    else $error("halted recoverable error mishandled");
  AST_CORR_EVENT: assert property (cev |=> o_corr_event)
    else $error("correctable event missing");
  AST_EVENT_CAUSE: assert property (o_corr_event |-> $past(cev))
    else $error("spurious correctable event");
  AST_STICKY_CAUSE: assert property ($rose(o_sticky_precise_abort) |-> $past(hrec))
    else $error("sticky flag set without cause");
  AST_PSLVERR: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
  AST_PSLVERR_ADDR: assert property (i_psel && i_penable |-> o_pslverr ==
    (i_paddr > AFR_OFS_CONTROL || i_paddr[1:0] != 2'h0))
    else $error("slave error does not match the address");
  AST_RECOV_HANDLED: assert property (rec && !i_debug_halt
    |=> o_abort_take != o_retry_access) else $error("recoverable error mishandled");
  cover property (hrec);
  cover property (o_retry_access);
  cover property (o_abort_take && !o_abort_precise);
endmodule
bind afr_recorder afr_recorder_properties i_afr_recorder_properties (.i_clock, .i_rstn,
  .i_psel, .i_penable, .i_paddr, .i_fault, .i_dma_corr, .i_debug_halt, .o_pslverr, .o_abort_take,
  .o_abort_precise, .o_retry_access, .o_corr_event, .o_sticky_precise_abort);
`default_nettype wire

// ==== tb/afr_core_model.sv ====
// pipeline and error detector model: issues one-cycle fault reports
// assumes its tasks are entered just after a rising clock edge
`default_nettype none
module afr_core_model
  import afr_pkg::*;
(
  input  wire logic        i_clock,
  output var afr_fault_s    o_fault,
  output var afr_dma_corr_s o_dma
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_fault = '0;
    o_dma = '0;
  end
  // one report; afterwards the idle fields show the inverse, not the last value
  task automatic send(input afr_fault_s f);
    afr_fault_s idle;
    idle = ~f;
    idle.valid = 1'b0;
    o_fault <= f;
    @(posedge i_clock);
    o_fault <= idle;
  endtask
  task automatic send_dma(input afr_dma_corr_s c);
    afr_dma_corr_s idle;
    idle = ~c;
    idle.valid = 1'b0;
    o_dma <= c;
    @(posedge i_clock);
    o_dma <= idle;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench for the recorder: apb reads of the fault registers after
// reports issued by the core model; waits up to 20 cycles for each apb answer
`default_nettype none
module testbench
  import afr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clock, i_rstn, psel, penable, pwrite, halt, pready, e, err;
  logic [AFR_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata, prdata, d;
  afr_fault_s            fault;
  afr_dma_corr_s         dma;
  int                    fails, checked;
  localparam logic [31:0] A1 = 32'h1000_0040, A2 = 32'h2000_0080, A3 = 32'h3000_00c4;
  afr_recorder i_afr_recorder (.i_clock, .i_rstn, .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(e), .i_fault(fault), .i_dma_corr(dma),
    .i_debug_halt(halt), .o_abort_take(), .o_abort_precise(), .o_retry_access(),
    .o_corr_event(), .o_sticky_precise_abort());
  afr_core_model i_afr_core_model (.i_clock, .o_fault(fault), .o_dma(dma));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      wrap_up;
    end
    d = prdata;
    err = e;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(nm, d, exp);
  endtask
  function automatic afr_fault_s flt(logic ins, mpu, afr_cause_e c, afr_src_e s,
      logic wr, co, logic [1:0] w, logic [7:0] st, logic [31:0] a);
    return '{1'b1, ins, mpu, c, s, wr, 1'b0, 1'b0, co, w, st, a, a ^ 32'h00ff_0000, ~a};
  endfunction
  initial begin
    {psel, penable, pwrite, halt} = '0;
    paddr = '0;
    pwdata = '0;
    i_rstn = 1'b0;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (int i = 0; i <= 40; i += 4) rd("reset word", i[7:0], '0);
    apb(1'b0, 8'h2c, '0);
    check("unmapped", {d[31:1], err}, 32'h1);
    $display("test reset done");
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_BUS_ERR, AFR_SRC_BUS, 0, 0, 0, 0, A1));
    rd("dfs", AFR_OFS_DATA_FAULT_STATUS, afr_fs_s'{'0, 0, 0, '0, AFR_FS_EXT});
    rd("dfa", AFR_OFS_DATA_FAULT_ADDRESS, A1);
    rd("adfs", AFR_OFS_AUX_DATA_FAULT_STATUS,
      afr_aux_s'{'0, 0, '0, 0, '0, AFR_SRC_BUS, '0, 0});
    rd("saved", AFR_OFS_ABORT_SAVED_STATUS, ~A1);
    rd("link", AFR_OFS_ABORT_LINK_REGISTER, (A1 ^ 32'h00ff_0000) + AFR_LINK_OFS_DATA);
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_BUS_ERR, AFR_SRC_BUS, 1, 0, 0, 0, A2));
    rd("dfs store", AFR_OFS_DATA_FAULT_STATUS, afr_fs_s'{'0, 1, 1, '0, AFR_FS_EXT});
    rd("dfa kept", AFR_OFS_DATA_FAULT_ADDRESS, A1);
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_CACHE_ECC, AFR_SRC_CACHE, 1, 0, 2, 8'h5a, A3));
    rd("adfs set", AFR_OFS_AUX_DATA_FAULT_STATUS,
      afr_aux_s'{'0, 8'h5a, '0, 0, '0, AFR_SRC_CACHE, '0, 2});
    rd("aifs kept", AFR_OFS_AUX_INSTR_FAULT_STATUS, '0);
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_CACHE_ECC, AFR_SRC_CACHE, 0, 0, 1, 8'h33, A3));
    rd("adfs no set", AFR_OFS_AUX_DATA_FAULT_STATUS,
      afr_aux_s'{'0, 0, '0, 0, '0, AFR_SRC_CACHE, '0, 1});
    $display("test data aborts done");
    i_afr_core_model.send(flt(1, 0, AFR_CAUSE_BUS_ERR, AFR_SRC_BUS, 0, 0, 0, 0, A2));
    rd("ifa", AFR_OFS_INSTR_FAULT_ADDRESS, A2);
    rd("ilink", AFR_OFS_ABORT_LINK_REGISTER,
      (A2 ^ 32'h00ff_0000) + AFR_LINK_OFS_INSTR);
    i_afr_core_model.send(flt(0, 1, AFR_CAUSE_TCM_EXT_ERR, AFR_SRC_FIRST_TCM, 0, 0, 0, 0, A3));
    rd("dfs mpu", AFR_OFS_DATA_FAULT_STATUS, afr_fs_s'{'0, 0, 0, '0, AFR_FS_MPU});
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_TCM_EXT_ERR, AFR_SRC_SECOND_TCM, 0, 1, 0, 0, A1));
    rd("adfs tcm", AFR_OFS_AUX_DATA_FAULT_STATUS,
      afr_aux_s'{'0, 0, '0, 0, '0, AFR_SRC_SECOND_TCM, '0, 0});
    $display("test fetch and tcm done");
    i_afr_core_model.send(flt(1, 0, AFR_CAUSE_TCM_ECC, AFR_SRC_FIRST_TCM, 0, 1, 0, 0, A3));
    rd("cfl fetch", AFR_OFS_CORRECTABLE_FAULT_LOC,
      afr_cfl_s'{'0, 0, '0, AFR_KIND_INSTR, '0, AFR_SRC_FIRST_TCM, '0, 0});
    rd("ifa kept", AFR_OFS_INSTR_FAULT_ADDRESS, A2);
    i_afr_core_model.send_dma('{1'b1, AFR_SRC_SECOND_TCM, 2'h0, 8'h11});
    rd("cfl dma", AFR_OFS_CORRECTABLE_FAULT_LOC,
      afr_cfl_s'{'0, 8'h11, '0, AFR_KIND_DMA, '0, AFR_SRC_SECOND_TCM, '0, 0});
    apb(1'b1, AFR_OFS_CONTROL, 32'h1);
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_CACHE_ECC, AFR_SRC_CACHE, 0, 1, 3, 0, A2));
    rd("adfs recov", AFR_OFS_AUX_DATA_FAULT_STATUS,
      afr_aux_s'{'0, 0, '0, 1, '0, AFR_SRC_CACHE, '0, 3});
    rd("cfl data", AFR_OFS_CORRECTABLE_FAULT_LOC,
      afr_cfl_s'{'0, 0, '0, AFR_KIND_DATA, '0, AFR_SRC_CACHE, '0, 3});
    $display("test correctable done");
    halt <= 1'b1;
    i_afr_core_model.send(flt(0, 0, AFR_CAUSE_TCM_RETRY, AFR_SRC_FIRST_TCM, 0, 0, 0, 0, A1));
    rd("sticky", AFR_OFS_DEBUG_STATUS_CONTROL, 32'h1);
    rd("link kept", AFR_OFS_ABORT_LINK_REGISTER,
      (A2 ^ 32'h00ff_0000) + AFR_LINK_OFS_DATA);
    apb(1'b1, AFR_OFS_DEBUG_STATUS_CONTROL, 32'h1);
    rd("sticky clear", AFR_OFS_DEBUG_STATUS_CONTROL, '0);
    $display("test debug halt done");
    wrap_up;
  end
endmodule
`default_nettype wire
